/* File: hw/d8t_top.sv */
// Dual 8-bit preload timer block with an APB slave register file.
// Assumes a single APB clock (pclk, 25 MHz) that is also the timers'
// system clock, and count pins that are asynchronous to it.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module d8t_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [d8t_pkg::D8T_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_a_ext_count_pin,
	input wire logic timer_b_ext_count_pin,
	output logic irq
);
	// All software-visible state that is not a counter
	typedef struct packed {
		logic [31:0] rdata; // Read data, captured in setup
		logic rerr; // Unmapped flag, captured in setup
		logic [2:0] ctrl_a; // Timer A clock select
		logic [2:0] ctrl_b; // Timer B clock select
		logic [7:0] reload_a; // Timer A preload
		logic [7:0] reload_b; // Timer B preload
		logic ovf_a; // Timer A overflow flag
		logic ovf_b; // Timer B overflow flag
		logic ie_a; // Timer A overflow interrupt enable
		logic ie_b; // Timer B overflow interrupt enable
		logic gie; // Global interrupt enable
	} d8t_regs_s;

	d8t_regs_s st_ff; // Registered state
	d8t_regs_s nxt_st; // Next state

	logic [d8t_pkg::D8T_NTAP-1:0] tick; // Prescaler taps
	logic [7:0] cnt_a; // Timer A count
	logic [7:0] cnt_b; // Timer B count
	logic ovf_pulse_a; // Timer A wrapped this cycle
	logic ovf_pulse_b; // Timer B wrapped this cycle
	logic setup_ph; // APB setup phase
	logic access_ph; // APB access phase
	logic wr_en; // Write takes effect this edge
	logic [5:0] idx; // Register index from address
	logic wr_cnt_a; // Software write to timer A count
	logic wr_cnt_b; // Software write to timer B count
	logic low_lane; // Byte lane 0 enabled for the write

	// Index is the word address; misaligned addresses are unmapped
	assign idx = paddr[7:2];

	// Decode used for the error answer and to block writes; rd_val has its own case
	function automatic logic is_mapped(input logic [5:0] i,
		input logic [1:0] lo);
		logic hit;
		hit = 1'b0;
		case (i)
			d8t_pkg::D8T_IDX_B_RELOAD: hit = 1'b1;
			d8t_pkg::D8T_IDX_B_COUNT: hit = 1'b1;
			d8t_pkg::D8T_IDX_B_CTRL: hit = 1'b1;
			d8t_pkg::D8T_IDX_A_RELOAD: hit = 1'b1;
			d8t_pkg::D8T_IDX_A_COUNT: hit = 1'b1;
			d8t_pkg::D8T_IDX_A_CTRL: hit = 1'b1;
			d8t_pkg::D8T_IDX_FLAGS: hit = 1'b1;
			d8t_pkg::D8T_IDX_MASK: hit = 1'b1;
			d8t_pkg::D8T_IDX_GIE: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit & (lo == 2'h0);
	endfunction

	// Read value of one register; unused bits read as zero
	function automatic logic [31:0] rd_val(input logic [5:0] i,
		input d8t_regs_s s, input logic [7:0] ca, input logic [7:0] cb);
		logic [7:0] v;
		v = 8'h00;
		case (i)
			d8t_pkg::D8T_IDX_B_RELOAD: v = s.reload_b;
			d8t_pkg::D8T_IDX_B_COUNT: v = cb;
			d8t_pkg::D8T_IDX_B_CTRL: v = {5'h00, s.ctrl_b};
			d8t_pkg::D8T_IDX_A_RELOAD: v = s.reload_a;
			d8t_pkg::D8T_IDX_A_COUNT: v = ca;
			d8t_pkg::D8T_IDX_A_CTRL: v = {5'h00, s.ctrl_a};
			d8t_pkg::D8T_IDX_FLAGS: begin
				v[d8t_pkg::D8T_BIT_A] = s.ovf_a;
				v[d8t_pkg::D8T_BIT_B] = s.ovf_b;
			end
			d8t_pkg::D8T_IDX_MASK: begin
				v[d8t_pkg::D8T_BIT_A] = s.ie_a;
				v[d8t_pkg::D8T_BIT_B] = s.ie_b;
			end
			d8t_pkg::D8T_IDX_GIE: v[d8t_pkg::D8T_BIT_GIE] = s.gie;
			default: v = 8'h00;
		endcase
		return {24'h000000, v};
	endfunction

	// Bus phases; the slave never stretches the access phase
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	// All registers sit in byte lane 0; other lanes are ignored
	assign low_lane = pstrb[0];
	assign wr_en = access_ph & pwrite & ~st_ff.rerr & low_lane;
	assign wr_cnt_a = wr_en & (idx == d8t_pkg::D8T_IDX_A_COUNT);
	assign wr_cnt_b = wr_en & (idx == d8t_pkg::D8T_IDX_B_COUNT);

	// Shared prescaler keeps both timers on the same rate grid
	d8t_prescaler u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	// Timer A
	d8t_channel u_timer_a (
		.pclk(pclk),
		.presetn(presetn),
		.clk_sel(st_ff.ctrl_a),
		.ext_pin(timer_a_ext_count_pin),
		.tick(tick),
		.cnt_wr(wr_cnt_a),
		.cnt_wdata(pwdata[7:0]),
		.reload_val(st_ff.reload_a),
		.count(cnt_a),
		.overflow(ovf_pulse_a)
	);

	// Timer B, with its own preload register
	d8t_channel u_timer_b (
		.pclk(pclk),
		.presetn(presetn),
		.clk_sel(st_ff.ctrl_b),
		.ext_pin(timer_b_ext_count_pin),
		.tick(tick),
		.cnt_wr(wr_cnt_b),
		.cnt_wdata(pwdata[7:0]),
		.reload_val(st_ff.reload_b),
		.count(cnt_b),
		.overflow(ovf_pulse_b)
	);

	// Register file next state
	always_comb begin
		nxt_st = st_ff;
		// Capture read data and decode in setup so outputs are flops
		if (setup_ph) begin
			nxt_st.rerr = ~is_mapped(idx, paddr[1:0]);
			if (pwrite) begin
				nxt_st.rdata = 32'h00000000;
			end else begin
				nxt_st.rdata = rd_val(idx, st_ff, cnt_a, cnt_b);
			end
		end
		// Writes land on the access edge
		if (wr_en) begin
			case (idx)
				d8t_pkg::D8T_IDX_A_CTRL: nxt_st.ctrl_a = pwdata[2:0];
				d8t_pkg::D8T_IDX_B_CTRL: nxt_st.ctrl_b = pwdata[2:0];
				d8t_pkg::D8T_IDX_A_RELOAD: nxt_st.reload_a = pwdata[7:0];
				d8t_pkg::D8T_IDX_B_RELOAD: nxt_st.reload_b = pwdata[7:0];
				d8t_pkg::D8T_IDX_FLAGS: begin
					// Write one to clear
					if (pwdata[d8t_pkg::D8T_BIT_A]) begin
						nxt_st.ovf_a = 1'b0;
					end
					if (pwdata[d8t_pkg::D8T_BIT_B]) begin
						nxt_st.ovf_b = 1'b0;
					end
				end
				d8t_pkg::D8T_IDX_MASK: begin
					nxt_st.ie_a = pwdata[d8t_pkg::D8T_BIT_A];
					nxt_st.ie_b = pwdata[d8t_pkg::D8T_BIT_B];
				end
				d8t_pkg::D8T_IDX_GIE: nxt_st.gie = pwdata[d8t_pkg::D8T_BIT_GIE];
				// Counts are written inside the channels
				default: nxt_st.ctrl_a = st_ff.ctrl_a;
			endcase
		end
		// Set after clear, so an overflow in the clear cycle survives
		if (ovf_pulse_a) begin
			nxt_st.ovf_a = 1'b1;
		end
		if (ovf_pulse_b) begin
			nxt_st.ovf_b = 1'b1;
		end
	end

	// Register file; every field starts at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Zero-wait answer; data and error were fixed in setup
	assign pready = access_ph;
	assign pslverr = access_ph & st_ff.rerr;
	assign prdata = st_ff.rdata;

	// Level interrupt gated by own enable and global enable
	assign irq = st_ff.gie & ((st_ff.ovf_a & st_ff.ie_a) | (st_ff.ovf_b & st_ff.ie_b));
endmodule

/* File: hw/d8t_pkg.sv */
// Constants shared by the dual 8-bit preload timer block.
// Assumes a single APB clock domain with 32-bit data and byte addressing.
package d8t_pkg;
	// Data width of counters and reload registers
	localparam int D8T_W = 8;
	// Width of the APB address bus seen by the block
	localparam int D8T_AW = 8;
	// Register indices; byte address is four times the index
	localparam logic [5:0] D8T_IDX_B_RELOAD = 6'h23;
	localparam logic [5:0] D8T_IDX_B_COUNT = 6'h24;
	localparam logic [5:0] D8T_IDX_B_CTRL = 6'h25;
	localparam logic [5:0] D8T_IDX_A_RELOAD = 6'h31;
	localparam logic [5:0] D8T_IDX_A_COUNT = 6'h32;
	localparam logic [5:0] D8T_IDX_A_CTRL = 6'h33;
	localparam logic [5:0] D8T_IDX_FLAGS = 6'h38;
	localparam logic [5:0] D8T_IDX_MASK = 6'h39;
	localparam logic [5:0] D8T_IDX_GIE = 6'h3a;
	// Bit positions inside flag, mask and global enable registers
	localparam int D8T_BIT_A = 1;
	localparam int D8T_BIT_B = 2;
	localparam int D8T_BIT_GIE = 0;
	// Reset values
	localparam logic [7:0] D8T_RST_8 = 8'h00;
	localparam logic [2:0] D8T_RST_CS = 3'h0;
	// Clock-select field width
	localparam int D8T_CSW = 3;
	// Clock-select codes
	typedef enum logic [2:0] {
		D8T_CS_STOP = 3'h0,
		D8T_CS_DIV1 = 3'h1,
		D8T_CS_DIV8 = 3'h2,
		D8T_CS_DIV64 = 3'h3,
		D8T_CS_DIV256 = 3'h4,
		D8T_CS_DIV1024 = 3'h5,
		D8T_CS_FALL = 3'h6,
		D8T_CS_RISE = 3'h7
	} d8t_cs_e;
	// Prescaler: width and low-bit counts for CK, /8, /64, /256, /1024
	localparam int D8T_PSW = 10;
	localparam int D8T_NTAP = 5;
	localparam int D8T_TAP_BITS [D8T_NTAP] = '{0, 3, 6, 8, 10};
endpackage

/* File: hw/d8t_prescaler.sv */
// Free-running system-clock prescaler shared by both timers.
// Assumes pclk is the system clock; taps pulse one cycle in N.
`timescale 1ns/1ps
module d8t_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	output logic [d8t_pkg::D8T_NTAP-1:0] tick
);
	// All state of the prescaler
	typedef struct packed {
		logic [d8t_pkg::D8T_PSW-1:0] cnt;
	} d8t_ps_s;

	d8t_ps_s st_ff; // Registered state
	d8t_ps_s nxt_st; // Next state

	// Count every cycle; wraps at 1024 so all taps stay aligned
	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnt = st_ff.cnt + 1'b1;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// One tap per rate: high when the low bits are all ones
	genvar gi;
	generate
		for (gi = 0; gi < d8t_pkg::D8T_NTAP; gi++) begin : g_tap
			localparam logic [d8t_pkg::D8T_PSW-1:0] TAP_MASK =
				d8t_pkg::D8T_PSW'((1 << d8t_pkg::D8T_TAP_BITS[gi]) - 1);
			assign tick[gi] = &(st_ff.cnt | ~TAP_MASK);
		end
	endgenerate
endmodule

/* File: hw/d8t_channel.sv */
// One 8-bit up-counting timer channel with preload on overflow.
// Assumes ext_pin is asynchronous and tick comes from d8t_prescaler.
`timescale 1ns/1ps
module d8t_channel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] clk_sel,
	input wire logic ext_pin,
	input wire logic [d8t_pkg::D8T_NTAP-1:0] tick,
	input wire logic cnt_wr,
	input wire logic [7:0] cnt_wdata,
	input wire logic [7:0] reload_val,
	output logic [7:0] count,
	output logic overflow
);
	// All state of one channel
	typedef struct packed {
		logic pin_s1; // First synchroniser stage
		logic pin_s2; // Second synchroniser stage
		logic pin_s3; // Previous synced level, for edges
		logic [7:0] count;
	} d8t_ch_s;

	d8t_ch_s st_ff; // Registered state
	d8t_ch_s nxt_st; // Next state
	logic adv; // Count enable this cycle

	// Select the count source and advance or reload
	always_comb begin
		nxt_st = st_ff;
		adv = 1'b0;
		overflow = 1'b0;
		// Pin passes two flops before any logic looks at it
		nxt_st.pin_s1 = ext_pin;
		nxt_st.pin_s2 = st_ff.pin_s1;
		nxt_st.pin_s3 = st_ff.pin_s2;
		case (d8t_pkg::d8t_cs_e'(clk_sel))
			d8t_pkg::D8T_CS_STOP: adv = 1'b0;
			d8t_pkg::D8T_CS_DIV1: adv = tick[0];
			d8t_pkg::D8T_CS_DIV8: adv = tick[1];
			d8t_pkg::D8T_CS_DIV64: adv = tick[2];
			d8t_pkg::D8T_CS_DIV256: adv = tick[3];
			d8t_pkg::D8T_CS_DIV1024: adv = tick[4];
			// One pulse per edge, so each edge counts once
			d8t_pkg::D8T_CS_FALL: adv = st_ff.pin_s3 & ~st_ff.pin_s2;
			d8t_pkg::D8T_CS_RISE: adv = ~st_ff.pin_s3 & st_ff.pin_s2;
			default: adv = 1'b0;
		endcase
		if (cnt_wr) begin
			// Write wins; counting resumes from it next cycle
			nxt_st.count = cnt_wdata;
		end else if (adv) begin
			if (&st_ff.count) begin
				// Wrap loads preload instead of zero
				nxt_st.count = reload_val;
				overflow = 1'b1;
			end else begin
				nxt_st.count = st_ff.count + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign count = st_ff.count;
endmodule

/* File: tb/d8t_monitor.sv */
// Port-level checker for the dual 8-bit timer block.
// Assumes zero-wait APB at the top ports and one clock domain.
`timescale 1ns/1ps
module d8t_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [d8t_pkg::D8T_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer_a_ext_count_pin,
	input wire logic timer_b_ext_count_pin,
	input wire logic irq
);
	// Byte addresses of the watched registers
	localparam logic [7:0] AR = {d8t_pkg::D8T_IDX_A_RELOAD, 2'h0};
	localparam logic [7:0] AN = {d8t_pkg::D8T_IDX_A_COUNT, 2'h0};
	localparam logic [7:0] AC = {d8t_pkg::D8T_IDX_A_CTRL, 2'h0};
	localparam logic [7:0] MK = {d8t_pkg::D8T_IDX_MASK, 2'h0};
	localparam logic [7:0] GE = {d8t_pkg::D8T_IDX_GIE, 2'h0};
	logic acc; // Access phase
	logic wr; // Write that the low strobe lets through
	assign acc = psel && penable;
	assign wr = acc && pwrite && pstrb[0];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_zero_wait: assert property (acc |-> pready)
		else $error("pready low in access phase");
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_ctrl_bits: assert property (acc && !pwrite && paddr == AC |-> prdata[7:3] == 5'h0)
		else $error("reserved control bits not zero");
	a_gie_off: assert property (wr && paddr == GE && !pwdata[0] |=> !irq)
		else $error("irq with global enable off");
	a_mask_off: assert property (wr && paddr == MK && pwdata[2:1] == 2'h0 |=> !irq)
		else $error("irq with both masks off");
	a_unmapped_err: assert property (acc && paddr == 8'h00 |-> pslverr)
		else $error("no error on unmapped address");
	a_mapped_ok: assert property (acc && paddr == AN |-> !pslverr)
		else $error("error on count register");
	a_reload_back: assert property (wr && paddr == AR ##3 acc && !pwrite && paddr == AR
		|-> prdata[7:0] == $past(pwdata[7:0], 3))
		else $error("reload value not read back");
endmodule
bind d8t_top d8t_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.timer_a_ext_count_pin(timer_a_ext_count_pin),
	.timer_b_ext_count_pin(timer_b_ext_count_pin));

/* File: tb/d8t_pin_model.sv */
// Count-pin source standing in for the world outside the timers.
// Assumes the bench calls toggle right after a rising edge.
`timescale 1ns/1ps
module d8t_pin_model (
	input wire logic pclk,
	output logic pin_a,
	output logic pin_b
);
	// Pins idle low until asked for edges
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// Each level held 4 cycles, long enough for the two-flop synchroniser
	task automatic toggle(input logic sel_b, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge pclk);
			if (sel_b)
				pin_b <= ~pin_b;
			else
				pin_a <= ~pin_a;
		end
		repeat (6) @(posedge pclk);
	endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench: APB register tests plus count-pin stimulus.
// Assumes d8t_top answers with zero wait states.
`timescale 1ns/1ps
module tb;
	localparam logic [5:0] BR = d8t_pkg::D8T_IDX_B_RELOAD;
	localparam logic [5:0] BN = d8t_pkg::D8T_IDX_B_COUNT;
	localparam logic [5:0] BC = d8t_pkg::D8T_IDX_B_CTRL;
	localparam logic [5:0] AR = d8t_pkg::D8T_IDX_A_RELOAD;
	localparam logic [5:0] AN = d8t_pkg::D8T_IDX_A_COUNT;
	localparam logic [5:0] AC = d8t_pkg::D8T_IDX_A_CTRL;
	localparam logic [5:0] FL = d8t_pkg::D8T_IDX_FLAGS;
	localparam logic [5:0] MK = d8t_pkg::D8T_IDX_MASK;
	localparam logic [5:0] GE = d8t_pkg::D8T_IDX_GIE;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_a, pin_b, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic err; // Response of the last transfer
	int n_fail = 0;
	int checks = 0;
	logic [5:0] regs [6] = '{BR, BN, BC, AR, AN, AC};
	int div [6] = '{0, 1, 8, 64, 256, 1024}; // Divisor per select code
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	d8t_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_a_ext_count_pin(pin_a),
		.timer_b_ext_count_pin(pin_b), .irq(irq));
	d8t_pin_model i_pins (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));
	// Verdict and end of run
	task automatic end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20) begin
			n_fail++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		cmp(rd, exp);
	endtask
	// Interrupt looked at once the write edge has settled
	task automatic irq_is(input logic exp);
		@(negedge pclk);
		cmp({31'h0, irq}, {31'h0, exp});
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i]) rdc(regs[i], 32'h0);
		xfer(1'b0, 6'h00, 8'h00);
		cmp({31'h0, err}, 32'h1);
		wr(AC, 8'hff);
		rdc(AC, 32'h07);
		// Exactly four ticks fit any window of four divisor periods
		for (int c = 1; c <= 5; c++) begin
			wr(AC, 8'(c));
			wr(AN, 8'h00);
			repeat (4 * div[c] - 1) @(posedge pclk);
			rdc(AN, 32'h04);
		end
		wr(AC, 8'h00);
		wr(AN, 8'h55);
		repeat (40) @(posedge pclk);
		rdc(AN, 32'h55);
		wr(AR, 8'hf0);
		rdc(AR, 32'hf0);
		wr(MK, 8'h06);
		wr(GE, 8'h01);
		wr(AC, 8'h01);
		wr(AN, 8'hfe);
		repeat (2) @(posedge pclk);
		rdc(AN, 32'hf1);
		wr(AC, 8'h00);
		rdc(FL, 32'h02);
		irq_is(1'b1);
		wr(MK, 8'h00);
		irq_is(1'b0);
		wr(MK, 8'h06);
		irq_is(1'b1);
		wr(GE, 8'h00);
		irq_is(1'b0);
		wr(GE, 8'h01);
		wr(FL, 8'h02);
		irq_is(1'b0);
		rdc(FL, 32'h0);
		wr(BR, 8'h10);
		wr(BC, 8'h06);
		wr(BN, 8'hfe);
		i_pins.toggle(1'b1, 4);
		rdc(BN, 32'h10);
		rdc(FL, 32'h04);
		irq_is(1'b1);
		wr(BC, 8'h07);
		i_pins.toggle(1'b1, 2);
		rdc(BN, 32'h11);
		wr(AC, 8'h07);
		wr(AN, 8'h00);
		i_pins.toggle(1'b0, 4);
		rdc(AN, 32'h02);
		// Low byte lane off: the count write must be ignored
		pstrb <= 4'he;
		wr(AN, 8'h77);
		pstrb <= 4'hf;
		rdc(AN, 32'h02);
		end_sim();
	end
endmodule
